// file: rtl/vts_pair_buf.sv
// two-entry valid/ready buffer for the outgoing vertex references
module vts_pair_buf
   import vts_pkg::*;
#(
   parameter int WIDTH = 16,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             srst,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   input  wire logic             out_ready,
   output logic                  out_valid,
   output logic [WIDTH-1:0]      out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_r;
   logic [PW-1:0]    rd_r;
   logic [PW:0]      cnt_r;
   logic             push;
   logic             pop;

   // honest full and empty from the occupancy count
   assign in_ready  = (cnt_r != (PW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // storage write
   always_ff @(posedge mclk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_r <= '0;
         rd_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == PW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == PW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
         end
      end
   end

   // occupancy
   always_ff @(posedge mclk) begin
      if (srst) begin
         cnt_r <= '0;
      end else if (push && !pop) begin
         cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

endmodule // vts_pair_buf

// file: rtl/vts_pkg.sv
// shared constants, types and header layout for the vertex thread payload stage
package vts_pkg;

   // header word indices inside the thread payload header
   localparam int HDR_WORDS       = 8;
   localparam int HW_HANDLE0      = 0;
   localparam int HW_HANDLE1      = 1;
   localparam int HW_MSG          = 2;
   localparam int HW_SAMPLER      = 3;
   localparam int HW_BINDING      = 4;
   localparam int HW_SCRATCH      = 5;
   localparam int HW_THREAD_ID    = 6;
   localparam int HW_SNAPSHOT     = 7;

   // field positions inside header words
   localparam int HANDLE_LSB      = 0;   // result handle, bits 8:0
   localparam int HANDLE_IDX_LSB  = 16;  // handle index, bits 24:16
   localparam int EXP_LSB         = 0;   // scratch exponent, bits 3:0
   localparam int PTR32_LSB       = 5;   // 32-byte pointers, bits 31:5
   localparam int SCR_OFF_LSB     = 10;  // 1 KB scratch offset, bits 31:10
   localparam int SLOT_LSB        = 0;   // outstanding thread slot, bits 3:0
   localparam int TID_LSB         = 0;   // thread id, bits 23:0
   localparam int SNAP_BIT        = 31;

   // widths
   localparam int HANDLE_W        = 9;
   localparam int SLOT_W          = 4;
   localparam int TID_W           = 24;
   localparam int EXP_W           = 4;
   localparam int PTR32_W         = 27;
   localparam int SCR_OFF_W       = 22;
   localparam int RD_W            = 6;
   localparam int KIND_W          = 5;

   // values after reset and fixed codes
   localparam logic [31:0]       WORD_ZERO    = 32'h0000_0000;
   localparam logic [TID_W-1:0]  TID_RST      = 24'h00_0000;
   localparam logic [8:0]        HIDX_RST     = 9'h000;
   localparam logic [7:0]        CH_MASK_ONE  = 8'h0f;   // lower four channels only
   localparam logic [7:0]        CH_MASK_TWO  = 8'hff;
   localparam logic [EXP_W-1:0]  EXP_MAX      = 4'hb;    // 2 MB per thread
   localparam int                SLOT_COUNT   = 16;

   // vertex reference travelling from the fetch stage to the next stage
   typedef struct packed {
      logic [HANDLE_W-1:0] handle;
      logic [KIND_W-1:0]   kind;     // primitive_kind_tag
      logic                begin_f;  // primitive_begin_flag
      logic                finish_f; // primitive_finish_flag
   } vts_vref_s;

   // state supplied by the pipeline state for this stage
   typedef struct packed {
      logic [SCR_OFF_W-1:0] scratch_base;
      logic [EXP_W-1:0]     scratch_exp;
      logic [PTR32_W-1:0]   binding_ptr;
      logic [PTR32_W-1:0]   sampler_ptr;
      logic [RD_W-1:0]      const_rd_off;
      logic [RD_W-1:0]      const_rd_len;
      logic [RD_W-1:0]      vert_rd_off;
      logic [RD_W-1:0]      vert_rd_len;
      logic [HANDLE_W-1:0]  const_handle;
      logic [SLOT_W-1:0]    max_threads_m1;
   } vts_cfg_s;

   // one thread dispatch request to the thread dispatcher
   typedef struct packed {
      logic [HDR_WORDS-1:0][31:0] hdr;
      logic [7:0]                 chan_mask;
      logic [HANDLE_W-1:0]        const_handle;
      logic [RD_W-1:0]            const_rd_off;
      logic [RD_W-1:0]            const_rd_len;
      logic [HANDLE_W-1:0]        vert_handle_lo;  // lanes 0-3 of each payload register
      logic [HANDLE_W-1:0]        vert_handle_hi;  // lanes 4-7 of each payload register
      logic [RD_W-1:0]            vert_rd_off;
      logic [RD_W-1:0]            vert_rd_len;
   } vts_disp_s;

   // dispatch sequencer states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE  = 6'b00_0001,
      ST_HOLD  = 6'b00_0010,
      ST_ALLOC = 6'b00_0100,
      ST_SEND  = 6'b00_1000,
      ST_EMIT0 = 6'b01_0000,
      ST_EMIT1 = 6'b10_0000
   } vts_state_e;

endpackage

// file: rtl/vts_slot_pool.sv
// pool of outstanding thread slots, taken at dispatch and returned at termination
module vts_slot_pool
   import vts_pkg::*;
#(
   parameter int SLOTS = SLOT_COUNT,
   parameter int IDW   = SLOT_W
) (
   // clock and reset
   input  wire logic           mclk,
   input  wire logic           srst,
   // allocation
   input  wire logic           alloc_req,
   input  wire logic [IDW-1:0] max_m1,
   output logic                alloc_ok,
   output logic [IDW-1:0]      alloc_id,
   // release on thread termination
   input  wire logic           free_valid,
   input  wire logic [IDW-1:0] free_id,
   // status
   output logic [IDW:0]        active
);

   logic [SLOTS-1:0] busy_r;
   logic [IDW:0]     active_r;
   logic             any_free;

   // lowest free slot wins; limited by the configured thread ceiling
   always_comb begin
      any_free = 1'b0;
      alloc_id = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (!busy_r[i]) begin
            any_free = 1'b1;
            alloc_id = IDW'(i);
         end
      end
   end

   assign alloc_ok = alloc_req && any_free && (active_r <= {1'b0, max_m1});
   assign active   = active_r;

   // a slot becomes free only after its thread has terminated
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_r <= '0;
      end else begin
         if (free_valid) begin
            busy_r[free_id] <= 1'b0;
         end
         if (alloc_ok) begin
            busy_r[alloc_id] <= 1'b1;
         end
      end
   end

   // active count; releasing an idle slot is ignored
   always_ff @(posedge mclk) begin
      if (srst) begin
         active_r <= '0;
      end else begin
         active_r <= active_r + (IDW+1)'(alloc_ok)
                     - (IDW+1)'(free_valid && busy_r[free_id]);
      end
   end

endmodule // vts_slot_pool

// file: rtl/vts_thread_payload.sv
// vertex shading stage: pairs vertices, builds thread payload headers, forwards references
//
// What this block does
// - header word 7 bit 31 set when the thread matched debug criteria, else clear.
// - header word 6 carries a 24-bit thread id unique over recent spawns.
// - header word 5 upper bits give the thread's 1 KB scratch offset.
// - header word 5 low four bits carry the outstanding thread slot.
// - header word 4 carries the 32-byte aligned binding table pointer.
// - header word 3 upper bits carry the 32-byte sampler table offset.
// - header word 3 low four bits give scratch size exponent, 0..11.
// - header word 2 is all zeros.
// - bits 24:16 of words 0 and 1 hold an internal handle index.
// - word 1 low nine bits hold the upper-channel result handle.
// - word 0 low nine bits hold the lower-channel result handle.
// - single-vertex threads get the upper channels masked off.
// - constant read offset and length are passed after the header.
// - vertex data interleaved, first vertex in lanes 0-3, second in 4-7.
// - handles differ for two vertices, match for one.
// - one output reference per input reference, in arrival order.
// - primitive tags copied untouched; nothing is read back.
// - vertices dispatched in pairs; a single only ahead of flush or state change.
module vts_thread_payload
   import vts_pkg::*;
#(
   parameter int OUT_DEPTH = 2
) (
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               srst,
   // stage state
   input  wire vts_cfg_s           cfg,
   input  wire logic               debug_match,
   // vertex references from the vertex fetch stage
   input  wire logic               in_valid,
   output logic                    in_ready,
   input  wire vts_vref_s          in_vref,
   input  wire logic               flush_req,
   // thread dispatch
   output logic                    disp_valid,
   input  wire logic               disp_ready,
   output vts_disp_s               disp,
   // thread termination from the execution units
   input  wire logic               term_valid,
   input  wire logic [SLOT_W-1:0]  term_slot,
   // vertex references to the next stage
   output logic                    out_valid,
   input  wire logic               out_ready,
   output vts_vref_s               out_vref,
   // status
   output logic [SLOT_W:0]         threads_active
);

   vts_state_e        state_r;
   vts_state_e        state_nxt;
   vts_vref_s         v0_r;
   vts_vref_s         v1_r;
   logic              pair_r;
   logic              snap_r;
   vts_disp_s         disp_r;
   logic [TID_W-1:0]  tid_r;
   logic [8:0]        hidx_r;
   logic              alloc_ok;
   logic [SLOT_W-1:0] alloc_id;
   logic              buf_in_ready;
   logic              buf_push;
   vts_vref_s         buf_data;
   logic              take_in;
   logic              go_single;

   // ------------------------------------------------------------
   // handshakes
   // ------------------------------------------------------------

   // new vertices only taken while nothing is being dispatched
   assign in_ready   = (state_r == ST_IDLE) || (state_r == ST_HOLD);
   assign take_in    = in_valid && in_ready;
   assign disp_valid = (state_r == ST_SEND);
   assign disp       = disp_r;

   // a held vertex goes alone only when a flush or state change is pending
   assign go_single  = (state_r == ST_HOLD) && !in_valid && flush_req;

   // references leave after their thread is accepted, one per vertex
   assign buf_push = ((state_r == ST_EMIT0) || (state_r == ST_EMIT1)) && buf_in_ready;
   assign buf_data = (state_r == ST_EMIT1) ? v1_r : v0_r;

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------

   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take_in) begin
               state_nxt = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (take_in || go_single) begin
               state_nxt = ST_ALLOC;
            end
         end
         ST_ALLOC: begin
            if (alloc_ok) begin
               state_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            if (disp_ready) begin
               state_nxt = ST_EMIT0;
            end
         end
         ST_EMIT0: begin
            if (buf_in_ready) begin
               state_nxt = pair_r ? ST_EMIT1 : ST_IDLE;
            end
         end
         ST_EMIT1: begin
            if (buf_in_ready) begin
               state_nxt = ST_IDLE;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk) begin
      if (srst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // vertex holding
   // ------------------------------------------------------------

   // first and second vertex of a thread; tags stored verbatim
   always_ff @(posedge mclk) begin
      if (srst) begin
         v0_r   <= '0;
         v1_r   <= '0;
         pair_r <= 1'b0;
      end else if (take_in && (state_r == ST_IDLE)) begin
         v0_r   <= in_vref;
         pair_r <= 1'b0;
      end else if (take_in && (state_r == ST_HOLD)) begin
         v1_r   <= in_vref;
         pair_r <= 1'b1;
      end
   end

   // debug match is sampled from the first vertex's arrival until the sequencer leaves ST_HOLD
   always_ff @(posedge mclk) begin
      if (srst) begin
         snap_r <= 1'b0;
      end else if (take_in && (state_r == ST_IDLE)) begin
         snap_r <= debug_match;
      end else if (in_ready && debug_match) begin
         snap_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // identifiers
   // ------------------------------------------------------------

   // thread id advances per spawn; wraps after 2^24 threads
   always_ff @(posedge mclk) begin
      if (srst) begin
         tid_r <= TID_RST;
      end else if ((state_r == ST_ALLOC) && alloc_ok) begin
         tid_r <= tid_r + 1'b1;
      end
   end

   // handle index steps by two per spawn so both lanes stay distinct
   always_ff @(posedge mclk) begin
      if (srst) begin
         hidx_r <= HIDX_RST;
      end else if ((state_r == ST_ALLOC) && alloc_ok) begin
         hidx_r <= hidx_r + 9'h002;
      end
   end

   // ------------------------------------------------------------
   // header assembly
   // ------------------------------------------------------------

   // whole payload captured once, so every reserved bit starts at zero
   always_ff @(posedge mclk) begin
      if (srst) begin
         disp_r <= '0;
      end else if ((state_r == ST_ALLOC) && alloc_ok) begin
         disp_r <= '0;
         // debug snapshot flag; rest of word reserved
         disp_r.hdr[HW_SNAPSHOT][SNAP_BIT] <= snap_r;
         disp_r.hdr[HW_THREAD_ID][TID_LSB +: TID_W] <= tid_r;
         // each slot owns its own scratch block beyond the stage base
         disp_r.hdr[HW_SCRATCH][SCR_OFF_LSB +: SCR_OFF_W] <=
            cfg.scratch_base + (SCR_OFF_W'(alloc_id) << cfg.scratch_exp);
         disp_r.hdr[HW_SCRATCH][SLOT_LSB +: SLOT_W] <= alloc_id;
         disp_r.hdr[HW_BINDING][PTR32_LSB +: PTR32_W] <= cfg.binding_ptr;
         disp_r.hdr[HW_SAMPLER][PTR32_LSB +: PTR32_W] <= cfg.sampler_ptr;
         // exponent beyond 2 MB is clamped to the top of the range
         disp_r.hdr[HW_SAMPLER][EXP_LSB +: EXP_W] <=
            (cfg.scratch_exp > EXP_MAX) ? EXP_MAX : cfg.scratch_exp;
         disp_r.hdr[HW_MSG] <= WORD_ZERO;
         disp_r.hdr[HW_HANDLE0][HANDLE_IDX_LSB +: 9] <= hidx_r;
         disp_r.hdr[HW_HANDLE0][HANDLE_LSB +: HANDLE_W] <= v0_r.handle;
         // a lone vertex repeats handle and index in the upper word
         if (pair_r) begin
            disp_r.hdr[HW_HANDLE1][HANDLE_IDX_LSB +: 9] <= hidx_r + 9'h001;
            disp_r.hdr[HW_HANDLE1][HANDLE_LSB +: HANDLE_W] <= v1_r.handle;
            disp_r.chan_mask      <= CH_MASK_TWO;
            disp_r.vert_handle_hi <= v1_r.handle;
         end else begin
            disp_r.hdr[HW_HANDLE1][HANDLE_IDX_LSB +: 9] <= hidx_r;
            disp_r.hdr[HW_HANDLE1][HANDLE_LSB +: HANDLE_W] <= v0_r.handle;
            disp_r.chan_mask      <= CH_MASK_ONE;
            disp_r.vert_handle_hi <= v0_r.handle;
         end
         // constant block follows the header, may be empty
         disp_r.const_handle   <= cfg.const_handle;
         disp_r.const_rd_off   <= cfg.const_rd_off;
         disp_r.const_rd_len   <= cfg.const_rd_len;
         // first vertex always in the lower lanes
         disp_r.vert_handle_lo <= v0_r.handle;
         disp_r.vert_rd_off    <= cfg.vert_rd_off;
         disp_r.vert_rd_len    <= cfg.vert_rd_len;
      end
   end

   // ------------------------------------------------------------
   // slot pool
   // ------------------------------------------------------------

   // termination from the thread returns its slot; results go to given handles only
   vts_slot_pool #(
      .SLOTS (SLOT_COUNT),
      .IDW   (SLOT_W)
   ) u_slots (
      .mclk       (mclk),
      .srst       (srst),
      .alloc_req  (state_r == ST_ALLOC),
      .max_m1     (cfg.max_threads_m1),
      .alloc_ok   (alloc_ok),
      .alloc_id   (alloc_id),
      .free_valid (term_valid),
      .free_id    (term_slot),
      .active     (threads_active)
   );

   // ------------------------------------------------------------
   // output references
   // ------------------------------------------------------------

   // stall downstream holds the sequencer in emit, never drops a reference
   vts_pair_buf #(
      .WIDTH ($bits(vts_vref_s)),
      .DEPTH (OUT_DEPTH)
   ) u_out_buf (
      .mclk      (mclk),
      .srst      (srst),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .in_data   (buf_data),
      .out_ready (out_ready),
      .out_valid (out_valid),
      .out_data  (out_vref)
   );

endmodule // vts_thread_payload

// file: verif/vts_disp_model.sv
// behavioural thread dispatcher and execution units for the payload stage
module vts_disp_model
   import vts_pkg::*;
(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         srst,
   // dispatch
   input  wire logic         disp_valid,
   output logic              disp_ready,
   input  wire vts_disp_s    disp,
   // termination
   output logic              term_valid,
   output logic [SLOT_W-1:0] term_slot
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SLOT_W-1:0] live_q[$];
   int                k;

   // quiet at time zero
   initial begin
      disp_ready = 1'b0;
      term_valid = 1'b0;
      term_slot  = 4'h0;
   end

   // accepted threads are recorded by slot until their termination is sent
   always @(posedge mclk) begin
      if (!srst && disp_valid && disp_ready) live_q.push_back(disp.hdr[HW_SCRATCH][3:0]);
   end

   // random acceptance and termination, off the sampling edge
   always @(negedge mclk) begin
      term_valid = 1'b0;
      term_slot  = ~term_slot; // no stale slot between pulses
      disp_ready = ($urandom % 2) == 0;
      if (srst) begin
         live_q.delete();
      end else if (live_q.size() > 0 && $urandom % 3 == 0) begin
         k = $urandom % live_q.size();
         term_slot  = live_q[k];
         term_valid = 1'b1;
         live_q.delete(k);
      end
   end
endmodule // vts_disp_model

// file: verif/vts_thread_payload_asserts.sv
// assertion checker for the vertex thread payload stage
module vts_thread_payload_asserts
   import vts_pkg::*;
(
   // clock and reset
   input wire logic              mclk,
   input wire logic              srst,
   // thread dispatch and termination
   input wire logic              disp_valid,
   input wire logic              disp_ready,
   input wire vts_disp_s         disp,
   input wire logic              term_valid,
   input wire logic [SLOT_W-1:0] term_slot,
   // references to the next stage
   input wire logic              out_valid,
   input wire logic              out_ready,
   input wire vts_vref_s         out_vref,
   input wire logic [SLOT_W:0]   threads_active
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [SLOT_COUNT-1:0] busy_r;
   logic [TID_W-1:0]      tid_r;
   logic                  have_r;
   wire logic             fire = disp_valid && disp_ready;

   // slots held by threads not yet terminated
   always_ff @(posedge mclk) begin
      if (srst) begin
         busy_r <= '0;
      end else begin
         if (term_valid) busy_r[term_slot] <= 1'b0;
         if (fire) busy_r[disp.hdr[HW_SCRATCH][3:0]] <= 1'b1;
      end
   end

   // last thread id handed out, to check the step
   always_ff @(posedge mclk) begin
      if (srst) begin
         have_r <= 1'b0;
         tid_r  <= TID_RST;
      end else if (fire) begin
         have_r <= 1'b1;
         tid_r  <= disp.hdr[HW_THREAD_ID][TID_W-1:0];
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   chk_snap_clear: assert property (
      disp_valid |-> disp.hdr[HW_SNAPSHOT][30:0] == 31'h0000_0000)
      else $error("snapshot word has reserved bits set");
   chk_tid_step: assert property (
      fire |-> disp.hdr[HW_THREAD_ID] == {8'h00, have_r ? tid_r + 24'h00_0001 : TID_RST})
      else $error("thread id did not step by one");
   chk_msg_zero: assert property (
      disp_valid |-> disp.hdr[HW_MSG] == WORD_ZERO) else $error("message word not zero");
   chk_exp_range: assert property (
      disp_valid |-> disp.hdr[HW_SAMPLER][4:0] <= 5'h0b) else $error("scratch exponent out of range");
   chk_single_same: assert property (
      disp_valid |-> (disp.chan_mask == CH_MASK_ONE) == (disp.hdr[HW_HANDLE0] == disp.hdr[HW_HANDLE1]))
      else $error("channel mask disagrees with handle words");
   chk_pair_index: assert property (
      disp_valid && disp.chan_mask == CH_MASK_TWO |->
         disp.hdr[HW_HANDLE1][24:16] == disp.hdr[HW_HANDLE0][24:16] + 9'h001)
      else $error("pair handle index not consecutive");
   chk_lo_handle: assert property (
      disp_valid |-> disp.hdr[HW_HANDLE0][8:0] == disp.vert_handle_lo &&
         {disp.hdr[HW_HANDLE0][31:25], disp.hdr[HW_HANDLE0][15:9]} == 14'h0000)
      else $error("lower handle word wrong");
   chk_ptr_low: assert property (
      disp_valid |-> disp.hdr[HW_BINDING][4:0] == 5'h00 && disp.hdr[HW_SCRATCH][9:4] == 6'h00)
      else $error("reserved pointer bits set");
   chk_slot_free: assert property (
      disp_valid |-> !busy_r[disp.hdr[HW_SCRATCH][3:0]]) else $error("busy slot reused");
   chk_disp_hold: assert property (
      disp_valid && !disp_ready |=> disp_valid && $stable(disp)) else $error("dispatch dropped");
   chk_out_hold: assert property (
      out_valid && !out_ready |=> out_valid && $stable(out_vref)) else $error("output dropped");
   chk_reset_quiet: assert property (
      $fell(srst) |-> !disp_valid && !out_valid && threads_active == '0)
      else $error("outputs busy after reset");

   // main scenarios reached
   cov_single: cover property (fire && disp.chan_mask == CH_MASK_ONE);
   cov_pair: cover property (fire && disp.chan_mask == CH_MASK_TWO);
   cov_disp_stall: cover property (disp_valid && !disp_ready);
   cov_out_stall: cover property (out_valid && !out_ready ##1 out_valid && !out_ready);
endmodule // vts_thread_payload_asserts

bind vts_thread_payload vts_thread_payload_asserts i_vts_thread_payload_asserts (
   .mclk, .srst, .disp_valid, .disp_ready, .disp, .term_valid, .term_slot,
   .out_valid, .out_ready, .out_vref, .threads_active);

// file: verif/vts_thread_payload_bench.sv
// self-checking bench for the vertex thread payload stage
module vts_thread_payload_bench
   import vts_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic              mclk, srst, debug_match, in_valid, in_ready, flush_req;
   logic              disp_valid, disp_ready, term_valid, out_valid, out_ready, single;
   logic [SLOT_W-1:0] term_slot;
   logic [SLOT_W:0]   threads_active;
   logic [8:0]        idx, h0, h1;
   logic [TID_W-1:0]  tid;
   logic [127:0]      rnd;
   logic [31:0]       s;
   vts_cfg_s          cfg;
   vts_vref_s         in_vref, out_vref;
   vts_disp_s         disp, e, e_d;
   vts_vref_s         ref_q[$];
   vts_disp_s         exp_q[$];
   logic [31:0]       scr_q[$];
   int                n_errors, n_compared, t, i, cyc;

   vts_thread_payload #(.OUT_DEPTH(2)) i_vts_thread_payload (
      .mclk(mclk), .srst(srst), .cfg(cfg), .debug_match(debug_match),
      .in_valid(in_valid), .in_ready(in_ready), .in_vref(in_vref), .flush_req(flush_req),
      .disp_valid(disp_valid), .disp_ready(disp_ready), .disp(disp),
      .term_valid(term_valid), .term_slot(term_slot),
      .out_valid(out_valid), .out_ready(out_ready), .out_vref(out_vref),
      .threads_active(threads_active));

   vts_disp_model i_vts_disp_model (
      .mclk(mclk), .srst(srst), .disp_valid(disp_valid), .disp_ready(disp_ready),
      .disp(disp), .term_valid(term_valid), .term_slot(term_slot));

   // free-running clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp_ref(vts_vref_s g, vts_vref_s x);
      n_compared++;
      if (g !== x) begin
         n_errors++;
         $display("Error %0t got %h exp %h", $time, g, x);
      end
   endtask

   task automatic cmp_disp(vts_disp_s g, vts_disp_s x);
      n_compared++;
      if (g !== x) begin
         n_errors++;
         $display("Error %0t got %h exp %h", $time, g, x);
      end
   endtask

   // bounded wait, at falling edges, for the input to accept
   task automatic wait_ready();
      int j;
      for (j = 0; j < 500 && in_ready !== 1'b1; j++) @(negedge mclk);
      if (in_ready !== 1'b1) begin
         n_errors++;
         end_sim();
      end
   endtask

   task automatic send(logic [8:0] h);
      @(negedge mclk);
      in_valid = 1'b1;
      in_vref  = {h, 5'($urandom), 2'($urandom)};
      wait_ready();
      @(posedge mclk);
      ref_q.push_back(in_vref);
   endtask

   // receiver stalls at random and once long enough to fill the buffer
   always @(negedge mclk) begin
      cyc++;
      out_ready = (cyc > 400 && cyc < 440) ? 1'b0 : ($urandom % 4 != 0);
   end

   // result watcher: oldest note against each result
   always @(posedge mclk) begin
      if (!srst && disp_valid && disp_ready) begin
         e_d = exp_q.pop_front();
         s   = scr_q.pop_front();
         e_d.hdr[HW_SCRATCH] = {s[31:10] + (22'(disp.hdr[HW_SCRATCH][3:0]) << s[3:0]),
                                6'h00, disp.hdr[HW_SCRATCH][3:0]};
         cmp_disp(disp, e_d);
      end
      if (!srst && out_valid && out_ready) cmp_ref(out_vref, ref_q.pop_front());
   end

   initial begin
      void'($urandom(32'h0f70));
      srst = 1'b1;
      in_valid = 1'b0;
      in_vref = '0;
      flush_req = 1'b0;
      debug_match = 1'b0;
      cfg = '0;
      out_ready = 1'b0;
      {n_errors, n_compared, cyc} = '0;
      idx = 9'h000;
      tid = TID_RST;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      srst = 1'b0;
      for (t = 0; t < 90; t++) begin
         @(negedge mclk);
         in_valid = 1'b0;
         wait_ready();
         // new state only while idle, so the held thread keeps its own
         rnd = {$urandom, $urandom, $urandom, $urandom};
         cfg = rnd[$bits(vts_cfg_s)-1:0];
         debug_match = rnd[127];
         single = (t % 3 == 2);
         h0 = rnd[8:0];
         h1 = h0 + 9'h001 + {1'b0, rnd[20:13]};
         e = '0;
         e.hdr[HW_HANDLE0] = {7'h00, idx, 7'h00, h0};
         e.hdr[HW_HANDLE1] = single ? e.hdr[HW_HANDLE0] : {7'h00, idx + 9'h001, 7'h00, h1};
         e.hdr[HW_SAMPLER] = {cfg.sampler_ptr, 1'b0,
                              (cfg.scratch_exp > EXP_MAX) ? EXP_MAX : cfg.scratch_exp};
         e.hdr[HW_BINDING] = {cfg.binding_ptr, 5'h00};
         e.hdr[HW_THREAD_ID] = {8'h00, tid};
         e.hdr[HW_SNAPSHOT] = {debug_match, 31'h0000_0000};
         e.chan_mask = single ? CH_MASK_ONE : CH_MASK_TWO;
         e.const_handle = cfg.const_handle;
         e.const_rd_off = cfg.const_rd_off;
         e.const_rd_len = cfg.const_rd_len;
         e.vert_handle_lo = h0;
         e.vert_handle_hi = single ? h0 : h1;
         e.vert_rd_off = cfg.vert_rd_off;
         e.vert_rd_len = cfg.vert_rd_len;
         exp_q.push_back(e);
         scr_q.push_back({cfg.scratch_base, 6'h00, cfg.scratch_exp});
         idx = idx + 9'h002;
         tid = tid + 24'h00_0001;
         send(h0);
         if (single) begin
            @(negedge mclk);
            in_valid = 1'b0;
            flush_req = 1'b1;
            repeat (3) @(negedge mclk);
            flush_req = 1'b0;
         end else begin
            send(h1);
         end
      end
      @(negedge mclk);
      in_valid = 1'b0;
      for (i = 0; i < 2000 && (exp_q.size() > 0 || ref_q.size() > 0); i++) @(negedge mclk);
      if (exp_q.size() > 0 || ref_q.size() > 0) n_errors++;
      end_sim();
   end
endmodule // vts_thread_payload_bench
